// ### pkg/chic_pkg.sv
// Purpose: Shared constants and carriers for the CD-ROM host interface control block
// Assumes: One clock domain, sub-CPU register port with 5-bit address
// Notes:   Register offsets are word indices on the plain sub-CPU port
package chic_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets (read side)
    localparam logic [4:0] CHIC_RD_CMD_IN    = 5'h00;  // Command FIFO / packet command
    localparam logic [4:0] CHIC_RD_STATUS    = 5'h01;  // host_if_status
    localparam logic [4:0] CHIC_RD_SECT3     = 5'h0F;  // sector_status_three
    localparam logic [4:0] CHIC_RD_SUB_HI    = 5'h13;  // Subcode address high
    localparam logic [4:0] CHIC_RD_HOST_CMD  = 5'h1A;  // host_command_reg
    localparam logic [4:0] CHIC_RD_DEV_CTRL  = 5'h1C;  // device_control_reg
    // Register offsets (write side)
    localparam logic [4:0] CHIC_WR_STAT_OUT  = 5'h00;  // Status output FIFO
    localparam logic [4:0] CHIC_WR_CONTROL   = 5'h01;  // host_if_control
    localparam logic [4:0] CHIC_WR_TRIGGER   = 5'h0A;  // transfer_trigger
    localparam logic [4:0] CHIC_WR_END_ACK   = 5'h0B;  // transfer_end_ack

    ////////////////////////////////////////////////////////////////////////////
    // Control field positions
    localparam int CHIC_CTL_CMD_MASK  = 7;
    localparam int CHIC_CTL_DTE_MASK  = 6;
    localparam int CHIC_CTL_DEC_MASK  = 5;
    localparam int CHIC_CTL_BRK_DIS   = 4;
    localparam int CHIC_CTL_DATA_WAIT = 3;
    localparam int CHIC_CTL_STAT_WAIT = 2;
    localparam int CHIC_CTL_DATA_OE   = 1;
    localparam int CHIC_CTL_STAT_OE   = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Values and sizes
    localparam logic [7:0] CHIC_CTRL_RESET  = 8'h00;
    localparam logic [7:0] CHIC_ATAPI_MASK  = 8'hE0;  // Control bits live in ATAPI mode
    localparam logic [7:0] CHIC_EMPTY_READ  = 8'hFF;  // Read of an empty command FIFO
    localparam logic [7:0] CHIC_DIAG_CMD    = 8'h90;  // Diagnostic command, ignores select
    localparam int         CHIC_FIFO_DEPTH  = 12;
    localparam int         CHIC_PTR_W       = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Sub-CPU register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } chic_bus_t;

    // Host side strobes in the legacy modes
    typedef struct packed {
        logic       cmd_wr;   // Host writes one command byte
        logic       stat_rd;  // Host reads one status byte
        logic [7:0] data;
    } chic_host_t;

    // ATAPI task-file events from the host side
    typedef struct packed {
        logic       cmd_reg_wr;   // Host wrote host_command_reg
        logic       drive_sel;    // This drive is selected
        logic       srst_set;     // Host set soft reset in device_control_reg
        logic       pkt_wr;       // Packet command byte written
        logic       pkt_done;     // Packet command complete
        logic       mem_done;     // Sub-CPU memory transfer finished
        logic [7:0] data;
    } chic_atapi_t;

endpackage : chic_pkg

// ### rtl/chic_host_if.sv
// Purpose: Host interface control/status: command and status FIFOs, transfer sequencing, interrupts
// Assumes: Inputs synchronous to clk_sys; data mover and decoder live outside
// Notes:   Status reads and command writes by the host are single-cycle strobes
//
// Function
// R1: Twelve-byte status FIFO carries bytes from sub-CPU to host.
// R2: Legacy status output write starts status transfer when output enable set.
// R3: Without wait, a status write drives status_ready_n low at once.
// R4: With wait and data ready idle, status_ready_n goes low and status busy sets.
// R5: While data transfer holds data_ready_n low, status_ready_n stays high; the code holds it high only while control bit 2 is low.
// R6: ATAPI packet command bytes accepted only while a data transfer runs.
// R7: Legacy twelve-byte command FIFO; emptying read sets command irq, then FFH.
// R8: Reset clears control; ATAPI mode uses only control bits 7 to 5.
// R9: Bits 7 to 5 mask command, end, decoder irqs; status bits untouched.
// R10: Bit 4 low lets host command write break transfers without end irq.
// R11: Bit 3 low postpones data transfer until status transfer completes.
// R12: Bit 2 low postpones status transfer until data transfer completes.
// R13: Bit 1 enables data transfer; clearing aborts running data transfer.
// R14: Bit 0 enables status transfer; clearing empties status FIFO and aborts.
// R15: In ATAPI mode status bits 1 and 0 read as zero.
// R16: ATAPI command irq on selected command write or 90H; read clears.
// R17: End irq on data transfer end, packet receipt, memory transfer; ack clears.
// R18: Decoder irq cleared by sector status read; subcode irq by subcode read.
// R19: Data busy set by trigger write, cleared when transfer completes.
// R20: ATAPI soft reset irq set by host, cleared by read, unmaskable.
// R21: Legacy status busy set by status write, cleared when host empties FIFO.
// R22: Legacy status bits 1,0 sample ready pins at each host access.
// R23: FIFOs keep write order and track fill exactly.
`timescale 1ns/1ps

module chic_host_if #(
    parameter int FIFO_DEPTH = chic_pkg::CHIC_FIFO_DEPTH
) (
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    input  wire logic                atapi_mode,
    input  wire chic_pkg::chic_bus_t bus,
    output logic [7:0]               bus_rdata,
    input  wire chic_pkg::chic_host_t   host,
    output logic [7:0]               host_stat_data,
    output logic                     status_ready_n,
    output logic                     data_ready_n,
    input  wire chic_pkg::chic_atapi_t  atapi,
    input  wire logic                data_xfer_done,
    input  wire logic                sector_ready,
    input  wire logic                subcode_ready,
    input  wire logic [7:0]          sector_status_three,
    input  wire logic [7:0]          subcode_addr_high,
    output logic                     data_xfer_busy,
    output logic                     data_xfer_abort,
    output logic                     sub_irq
);
    import chic_pkg::*;

    // Wrap a FIFO pointer at the configured depth
    function automatic logic [CHIC_PTR_W-1:0] next_ptr(input logic [CHIC_PTR_W-1:0] p);
        next_ptr = (p == CHIC_PTR_W'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0]            host_if_control;
    logic [7:0]            cmd_mem [FIFO_DEPTH];
    logic [7:0]            stat_mem [FIFO_DEPTH];
    logic [CHIC_PTR_W-1:0] cmd_wp, cmd_rp, cmd_cnt;
    logic [CHIC_PTR_W-1:0] stat_wp, stat_rp, stat_cnt;
    logic                  status_xfer_busy;
    logic                  command_interrupt;
    logic                  transfer_end_interrupt;
    logic                  decoder_interrupt;
    logic                  subcode_interrupt;
    logic                  soft_reset_interrupt;
    logic [1:0]            pin_sample;
    logic [7:0]            host_cmd_byte;
    logic [7:0]            dev_ctrl_byte;
    logic                  data_running;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    wire legacy       = ~atapi_mode;
    wire [7:0] ctl    = atapi_mode ? (host_if_control & CHIC_ATAPI_MASK) : host_if_control; // [R8]
    // Waits are active low; in ATAPI mode the masked zero would enable them, so force off
    wire data_wait    = legacy & ~ctl[CHIC_CTL_DATA_WAIT];
    wire stat_wait    = legacy & ~ctl[CHIC_CTL_STAT_WAIT];
    wire data_oe      = atapi_mode | ctl[CHIC_CTL_DATA_OE];
    wire stat_oe      = ctl[CHIC_CTL_STAT_OE];
    wire brk_en       = legacy & ~ctl[CHIC_CTL_BRK_DIS];

    wire wr_stat_port = bus.wr & (bus.addr == CHIC_WR_STAT_OUT);
    wire wr_control   = bus.wr & (bus.addr == CHIC_WR_CONTROL);
    wire wr_trigger   = bus.wr & (bus.addr == CHIC_WR_TRIGGER);
    wire wr_end_ack   = bus.wr & (bus.addr == CHIC_WR_END_ACK);
    wire rd_cmd_port  = bus.rd & (bus.addr == CHIC_RD_CMD_IN);
    wire rd_status    = bus.rd & (bus.addr == CHIC_RD_STATUS);
    wire rd_sect3     = bus.rd & (bus.addr == CHIC_RD_SECT3);
    wire rd_sub_hi    = bus.rd & (bus.addr == CHIC_RD_SUB_HI);
    wire rd_host_cmd  = bus.rd & (bus.addr == CHIC_RD_HOST_CMD);
    wire rd_dev_ctrl  = bus.rd & (bus.addr == CHIC_RD_DEV_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    // Fill state
    wire cmd_empty  = (cmd_cnt == '0);                              // [R23]
    wire cmd_full   = (cmd_cnt == CHIC_PTR_W'(FIFO_DEPTH));
    wire stat_empty = (stat_cnt == '0);
    wire stat_full  = (stat_cnt == CHIC_PTR_W'(FIFO_DEPTH));

    // Command break and control-bit aborts
    wire cmd_break   = brk_en & host.cmd_wr;                        // [R10]
    wire doe_clear   = wr_control & legacy & ~bus.wdata[CHIC_CTL_DATA_OE] & data_xfer_busy; // [R13]
    wire soe_off     = legacy & ~stat_oe;                           // [R14]
    wire stat_flush  = soe_off | (cmd_break & status_xfer_busy);

    // Ready pins; a data transfer already running is never paused, so waits cannot deadlock
    wire data_hold   = data_wait & status_xfer_busy & ~data_running; // [R11]
    wire stat_hold   = stat_wait & ~data_ready_n;                   // [R12] [R5]
    assign data_ready_n   = ~(legacy & data_xfer_busy & data_oe & ~data_hold);
    assign status_ready_n = ~(legacy & status_xfer_busy & ~stat_empty & ~stat_hold); // [R3] [R4]

    // Pushes and pops
    wire pkt_push  = atapi_mode & atapi.pkt_wr & data_xfer_busy;    // [R6]
    wire cmd_push  = ~cmd_full & ((legacy & host.cmd_wr) | pkt_push);
    wire [7:0] cmd_in = atapi_mode ? atapi.data : host.data;
    wire cmd_pop   = rd_cmd_port & ~cmd_empty;
    wire stat_push = legacy & wr_stat_port & stat_oe & ~stat_full;  // [R1] [R2]
    wire stat_pop  = host.stat_rd & ~status_ready_n;
    wire host_acc  = legacy & (host.cmd_wr | host.stat_rd);

    // Interrupt events
    wire cmd_irq_set = (legacy & cmd_pop & (cmd_cnt == CHIC_PTR_W'(1)))             // [R7]
                     | (atapi_mode & atapi.cmd_reg_wr
                        & (atapi.drive_sel | (atapi.data == CHIC_DIAG_CMD)));       // [R16]
    wire cmd_irq_clr = (legacy & host.cmd_wr) | (atapi_mode & rd_host_cmd);
    wire dte_set     = (data_xfer_busy & data_xfer_done)
                     | (atapi_mode & (atapi.pkt_done | atapi.mem_done));             // [R17]
    wire srst_set    = atapi_mode & atapi.srst_set;                                 // [R20]

    // Status byte; low bits only carry meaning in legacy modes
    wire stat_bit2 = atapi_mode ? soft_reset_interrupt : status_xfer_busy;
    wire [7:0] status_byte = {command_interrupt, transfer_end_interrupt, decoder_interrupt,
                              subcode_interrupt, data_xfer_busy, stat_bit2,
                              legacy ? pin_sample : 2'b00};                          // [R15]

    // Read mux; unmapped addresses return zero
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        case (bus.addr)
            CHIC_RD_CMD_IN:   next_rdata = cmd_empty ? CHIC_EMPTY_READ : cmd_mem[cmd_rp]; // [R7]
            CHIC_RD_STATUS:   next_rdata = status_byte;
            CHIC_RD_SECT3:    next_rdata = sector_status_three;
            CHIC_RD_SUB_HI:   next_rdata = subcode_addr_high;
            CHIC_RD_HOST_CMD: next_rdata = host_cmd_byte;
            CHIC_RD_DEV_CTRL: next_rdata = dev_ctrl_byte;
            default:          next_rdata = 8'h00;
        endcase
    end

    // Masked sub-CPU interrupt; soft reset cannot be masked
    assign sub_irq = (command_interrupt & ctl[CHIC_CTL_CMD_MASK])
                   | (transfer_end_interrupt & ctl[CHIC_CTL_DTE_MASK])
                   | (decoder_interrupt & ctl[CHIC_CTL_DEC_MASK])
                   | soft_reset_interrupt;                                            // [R9] [R20]

    ////////////////////////////////////////////////////////////////////////////
    // Control register and read data
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            host_if_control <= CHIC_CTRL_RESET;                 // [R8]
            bus_rdata       <= 8'h00;
        end else begin
            if (wr_control)
                host_if_control <= bus.wdata;
            if (bus.rd)
                bus_rdata <= next_rdata;
        end
    end

    // Command and status FIFO storage, written in order
    always_ff @(posedge clk_sys) begin
        if (cmd_push)
            cmd_mem[cmd_wp] <= cmd_in;                          // [R23]
        if (stat_push)
            stat_mem[stat_wp] <= bus.wdata;
    end

    // Command FIFO pointers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmd_wp  <= '0;
            cmd_rp  <= '0;
            cmd_cnt <= '0;
        end else begin
            if (cmd_push)
                cmd_wp <= next_ptr(cmd_wp);
            if (cmd_pop)
                cmd_rp <= next_ptr(cmd_rp);
            cmd_cnt <= cmd_cnt + CHIC_PTR_W'(cmd_push) - CHIC_PTR_W'(cmd_pop); // [R23]
        end
    end

    // Status FIFO pointers; a flush beats any push in the same cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stat_wp  <= '0;
            stat_rp  <= '0;
            stat_cnt <= '0;
        end else if (stat_flush) begin
            stat_wp  <= '0;                                     // [R14] [R10]
            stat_rp  <= '0;
            stat_cnt <= '0;
        end else begin
            if (stat_push)
                stat_wp <= next_ptr(stat_wp);
            if (stat_pop)
                stat_rp <= next_ptr(stat_rp);
            stat_cnt <= stat_cnt + CHIC_PTR_W'(stat_push) - CHIC_PTR_W'(stat_pop); // [R1]
        end
    end

    // Status byte to host, registered
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            host_stat_data <= 8'h00;
        else if (stat_pop)
            host_stat_data <= stat_mem[stat_rp];
    end

    // Status transfer busy: set by write, cleared when host drains the FIFO
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            status_xfer_busy <= 1'b0;
        else if (stat_flush | atapi_mode)
            status_xfer_busy <= 1'b0;                           // [R14]
        else if (stat_push)
            status_xfer_busy <= 1'b1;                           // [R21] [R2]
        else if (stat_pop & (stat_cnt == CHIC_PTR_W'(1)))
            status_xfer_busy <= 1'b0;                           // [R21]
    end

    // Data transfer busy and abort pulse
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            data_xfer_busy  <= 1'b0;
            data_xfer_abort <= 1'b0;
            data_running    <= 1'b0;
        end else begin
            data_xfer_abort <= data_xfer_busy & (doe_clear | cmd_break);
            data_running    <= data_xfer_busy & (data_running | ~data_ready_n); // [R5]
            if (wr_trigger)
                data_xfer_busy <= 1'b1;                         // [R19]
            else if (data_xfer_done | doe_clear | cmd_break)
                data_xfer_busy <= 1'b0;                         // [R19] [R13] [R10]
        end
    end

    // Sticky interrupt flags; a set in the clearing cycle wins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            command_interrupt      <= 1'b0;
            transfer_end_interrupt <= 1'b0;
            decoder_interrupt      <= 1'b0;
            subcode_interrupt      <= 1'b0;
            soft_reset_interrupt   <= 1'b0;
        end else begin
            command_interrupt      <= cmd_irq_set | (command_interrupt & ~cmd_irq_clr);   // [R7] [R16]
            transfer_end_interrupt <= dte_set | (transfer_end_interrupt & ~wr_end_ack);   // [R17] [R10]
            decoder_interrupt      <= sector_ready | (decoder_interrupt & ~rd_sect3);     // [R18]
            subcode_interrupt      <= subcode_ready | (subcode_interrupt & ~rd_sub_hi);   // [R18]
            soft_reset_interrupt   <= srst_set | (soft_reset_interrupt & ~rd_dev_ctrl);   // [R20]
        end
    end

    // Pin samples and ATAPI task-file copies
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_sample    <= 2'b11;
            host_cmd_byte <= 8'h00;
            dev_ctrl_byte <= 8'h00;
        end else begin
            if (host_acc)
                pin_sample <= {data_ready_n, status_ready_n};   // [R22]
            if (atapi_mode & atapi.cmd_reg_wr)
                host_cmd_byte <= atapi.data;
            if (srst_set)
                dev_ctrl_byte <= atapi.data;
        end
    end

endmodule // chic_host_if

// ### sim/chic_host_if_assertions.sv
// Purpose: Port-level checks on the host interface control block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to every chic_host_if instance below
`timescale 1ns/1ps

module chic_host_if_checker (
    input wire logic                 clk_sys,
    input wire logic                 rst_b,
    input wire logic                 atapi_mode,
    input wire chic_pkg::chic_bus_t  bus,
    input wire logic [7:0]           bus_rdata,
    input wire chic_pkg::chic_host_t host,
    input wire logic [7:0]           host_stat_data,
    input wire logic                 status_ready_n,
    input wire chic_pkg::chic_atapi_t atapi,
    input wire logic                 data_xfer_done,
    input wire logic [7:0]           sector_status_three,
    input wire logic                 data_xfer_busy,
    input wire logic                 data_xfer_abort,
    input wire logic                 sub_irq
);
    import chic_pkg::*;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    // Steps of the sub-CPU and host handshakes
    sequence s_trigger;       bus.wr && bus.addr == CHIC_WR_TRIGGER; endsequence
    sequence s_refused_pop;   host.stat_rd && status_ready_n; endsequence
    sequence s_stat_off;      bus.wr && bus.addr == CHIC_WR_CONTROL && !bus.wdata[CHIC_CTL_STAT_OE]; endsequence
    sequence s_sector_read;   bus.rd && bus.addr == CHIC_RD_SECT3; endsequence

    ////////////////////////////////////////////////////////////////////////////
    // Same-cycle done left out
    a_trigger_sets_busy: assert property (s_trigger ##0 !data_xfer_done |=> data_xfer_busy)
        else $error("busy not set by trigger write");
    a_done_ends_busy: assert property (data_xfer_busy && data_xfer_done && !(bus.wr && bus.addr == CHIC_WR_TRIGGER)
        |=> !data_xfer_busy)
        else $error("busy not cleared at transfer end");
    a_refused_pop_holds: assert property (s_refused_pop |=> $stable(host_stat_data))
        else $error("status byte popped while not ready");
    a_atapi_low_bits: assert property (atapi_mode && bus.rd && bus.addr == CHIC_RD_STATUS
        |=> bus_rdata[1:0] == 2'b00)
        else $error("low status bits not zero in packet mode");
    a_srst_unmasked: assert property (atapi_mode && atapi.srst_set |=> sub_irq)
        else $error("soft reset did not raise sub-CPU interrupt");
    a_abort_pulse: assert property (data_xfer_abort |-> $past(data_xfer_busy) ##1 !data_xfer_abort)
        else $error("abort pulse without running transfer or too long");
    a_stat_off_flush: assert property (s_stat_off |=> ##1 status_ready_n)
        else $error("status ready stayed low after status disable");
    a_sector_passes: assert property (s_sector_read |=> bus_rdata == $past(sector_status_three))
        else $error("sector status read did not return input value");

endmodule // chic_host_if_checker

bind chic_host_if chic_host_if_checker chk_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .atapi_mode(atapi_mode), .bus(bus), .bus_rdata(bus_rdata),
    .host(host), .host_stat_data(host_stat_data), .status_ready_n(status_ready_n), .atapi(atapi),
    .data_xfer_done(data_xfer_done), .sector_status_three(sector_status_three),
    .data_xfer_busy(data_xfer_busy), .data_xfer_abort(data_xfer_abort), .sub_irq(sub_irq)
);

// ### sim/chic_host_model.sv
// Purpose: Host computer model on the legacy command and status byte lanes
// Assumes: Host strobes are single-cycle, taken on the rising edge
// Notes:   Data lane shows an inverted pattern outside writes
`timescale 1ns/1ps

module chic_host_model (
    input  wire logic                 clk_sys,
    input  wire logic                 status_ready_n,
    input  wire logic [7:0]           host_stat_data,
    output chic_pkg::chic_host_t      host
);
    import chic_pkg::*;

    initial host = '0;

    ////////////////////////////////////////////////////////////////////////////
    // One command byte; lane then shows inverse
    task automatic push(input logic [7:0] d);
        @(posedge clk_sys);
        host <= '{cmd_wr: 1'b1, stat_rd: 1'b0, data: d};
        @(posedge clk_sys);
        host <= '{cmd_wr: 1'b0, stat_rd: 1'b0, data: ~d};
    endtask

    // Polls ready before reading
    task automatic pop(output logic [7:0] d, output logic ok);
        int n;
        ok = 1'b0;
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge clk_sys);
            ok = (status_ready_n === 1'b0);
        end
        if (ok) begin
            host <= '{cmd_wr: 1'b0, stat_rd: 1'b1, data: host.data};
            @(posedge clk_sys);
            host <= '{cmd_wr: 1'b0, stat_rd: 1'b0, data: ~host.data};
            #1 d = host_stat_data;
        end
    endtask

endmodule // chic_host_model

// ### sim/test_chic_host_if.sv
// Purpose: Self-checking bench for the host interface control block
// Assumes: 40 MHz clock, reset held four cycles
// Notes:   Scenarios run in order and share interrupt state
`timescale 1ns/1ps

module test_chic_host_if;
    import chic_pkg::*;

    logic         clk_sys = 1'b0;
    logic         rst_b = 1'b0;
    logic         atapi_mode = 1'b0;
    chic_bus_t    bus = '0;
    chic_host_t   host;
    chic_atapi_t  atapi = '0;
    logic         done = 1'b0, sect = 1'b0, subc = 1'b0;
    logic [7:0]   bus_rdata, host_stat_data, d, s3 = 8'h5A, sh = 8'h02;
    logic         status_ready_n, data_ready_n, busy, abort, sub_irq, ok;
    int           num_errors = 0, check_count = 0, aborts = 0;

    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (abort === 1'b1) aborts++;

    chic_host_if dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .atapi_mode(atapi_mode), .bus(bus),
        .bus_rdata(bus_rdata), .host(host), .host_stat_data(host_stat_data), .status_ready_n(status_ready_n),
        .data_ready_n(data_ready_n), .atapi(atapi), .data_xfer_done(done), .sector_ready(sect),
        .subcode_ready(subc), .sector_status_three(s3), .subcode_addr_high(sh),
        .data_xfer_busy(busy), .data_xfer_abort(abort), .sub_irq(sub_irq));
    chic_host_model host_u (.clk_sys(clk_sys), .status_ready_n(status_ready_n),
        .host_stat_data(host_stat_data), .host(host));

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycles and comparison
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk_sys) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk_sys) bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        @(posedge clk_sys) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys) bus <= '0;
        #1 v = bus_rdata;
    endtask
    task pop_chk(input logic [7:0] exp);
        host_u.pop(d, ok);
        chk({7'h0, ok}, 8'h01);
        if (ok) chk(d, exp);
    endtask
    task end_xfer();
        @(posedge clk_sys) done <= 1'b1;
        @(posedge clk_sys) done <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset();
        rd(CHIC_RD_STATUS, d); chk(d, 8'h03);
        chk({7'h0, sub_irq}, 8'h00);
        rd(5'h05, d); chk(d, 8'h00);
    endtask
    task t_stat_fifo();
        wr(CHIC_WR_CONTROL, 8'h05);
        for (int i = 0; i < 13; i++) wr(CHIC_WR_STAT_OUT, 8'h10 + i[7:0]);
        chk({7'h0, status_ready_n}, 8'h00);
        rd(CHIC_RD_STATUS, d); chk({7'h0, d[2]}, 8'h01);
        for (int i = 0; i < 12; i++) pop_chk(8'h10 + i[7:0]);
        chk({7'h0, status_ready_n}, 8'h01);
        rd(CHIC_RD_STATUS, d); chk({7'h0, d[2]}, 8'h00);
    endtask
    task t_wait();
        wr(CHIC_WR_CONTROL, 8'h03);
        wr(CHIC_WR_STAT_OUT, 8'h3C);
        wr(CHIC_WR_TRIGGER, 8'h00);
        chk({6'h0, busy, data_ready_n}, 8'h03);
        pop_chk(8'h3C);
        @(posedge clk_sys) #1 chk({7'h0, data_ready_n}, 8'h00);
        wr(CHIC_WR_STAT_OUT, 8'hA5);
        repeat (3) @(posedge clk_sys);
        #1 chk({7'h0, status_ready_n}, 8'h01);
        end_xfer();
        chk({6'h0, busy, status_ready_n}, 8'h00);
        pop_chk(8'hA5);
    endtask
    task t_abort();
        int a0;
        a0 = aborts;
        wr(CHIC_WR_TRIGGER, 8'h00);
        wr(CHIC_WR_CONTROL, 8'h01);
        repeat (2) @(posedge clk_sys);
        #1 chk({7'h0, busy}, 8'h00);
        chk(aborts[7:0] - a0[7:0], 8'h01);
        wr(CHIC_WR_STAT_OUT, 8'h77);
        wr(CHIC_WR_CONTROL, 8'h00);
        @(posedge clk_sys) #1 chk({7'h0, status_ready_n}, 8'h01);
    endtask
    task t_cmd_fifo();
        wr(CHIC_WR_END_ACK, 8'h00);
        wr(CHIC_WR_CONTROL, 8'h03);
        wr(CHIC_WR_TRIGGER, 8'h00);
        host_u.push(8'hC1); host_u.push(8'hC2); host_u.push(8'hC3);
        @(posedge clk_sys) #1 chk({7'h0, busy}, 8'h00);
        for (int i = 1; i < 4; i++) begin
            rd(CHIC_RD_CMD_IN, d); chk(d, 8'hC0 + i[7:0]);
        end
        rd(CHIC_RD_STATUS, d); chk({6'h0, d[7:6]}, 8'h02);
        rd(CHIC_RD_CMD_IN, d); chk(d, CHIC_EMPTY_READ);
        wr(CHIC_WR_CONTROL, 8'h13);
        wr(CHIC_WR_TRIGGER, 8'h00);
        host_u.push(8'h44);
        @(posedge clk_sys) #1 chk({7'h0, busy}, 8'h01);
        end_xfer();
        rd(CHIC_RD_STATUS, d); chk({7'h0, d[6]}, 8'h01);
        rd(CHIC_RD_CMD_IN, d); chk(d, 8'h44);
    endtask
    task t_irq();
        wr(CHIC_WR_CONTROL, 8'h40); chk({7'h0, sub_irq}, 8'h01);
        wr(CHIC_WR_CONTROL, 8'h00); chk({7'h0, sub_irq}, 8'h00);
        rd(CHIC_RD_STATUS, d); chk({7'h0, d[6]}, 8'h01);
        wr(CHIC_WR_END_ACK, 8'h00);
        rd(CHIC_RD_STATUS, d); chk({7'h0, d[6]}, 8'h00);
        @(posedge clk_sys) sect <= 1'b1;
        @(posedge clk_sys) begin sect <= 1'b0; subc <= 1'b1; end
        @(posedge clk_sys) subc <= 1'b0;
        rd(CHIC_RD_STATUS, d); chk({6'h0, d[5:4]}, 8'h03);
        rd(CHIC_RD_SECT3, d); chk(d, 8'h5A);
        rd(CHIC_RD_SUB_HI, d); chk(d, 8'h02);
        rd(CHIC_RD_STATUS, d); chk({6'h0, d[5:4]}, 8'h00);
    endtask
    task t_atapi();
        @(posedge clk_sys) atapi_mode <= 1'b1;
        rd(CHIC_RD_HOST_CMD, d);
        @(posedge clk_sys) atapi <= '{srst_set: 1'b1, default: '0};
        @(posedge clk_sys) atapi <= '{cmd_reg_wr: 1'b1, data: 8'hA0, default: '0};
        @(posedge clk_sys) atapi <= '0;
        #1 chk({7'h0, sub_irq}, 8'h01);
        rd(CHIC_RD_STATUS, d); chk({d[7], d[2], d[1:0]}, 8'h04);
        rd(CHIC_RD_DEV_CTRL, d);
        @(posedge clk_sys) atapi <= '{cmd_reg_wr: 1'b1, data: CHIC_DIAG_CMD, default: '0};
        @(posedge clk_sys) atapi <= '0;
        rd(CHIC_RD_STATUS, d); chk({6'h0, d[7], d[2]}, 8'h02);
        rd(CHIC_RD_HOST_CMD, d); chk(d, CHIC_DIAG_CMD);
        rd(CHIC_RD_STATUS, d); chk({7'h0, d[7]}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and main sequence
    task results();
        $display("Checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset(); t_stat_fifo(); t_wait(); t_abort(); t_cmd_fifo(); t_irq(); t_atapi();
        results();
    end

endmodule // test_chic_host_if
